// [hw/nvs_pkg.sv]
// nvs_pkg: shared constants, command codes and carriers for the nvsram host controller.
// assumes a 200 MHz clock; all pin timing is counted in whole cycles of it.
package nvs_pkg;

  // ----------------------------------------------------------------
  // clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 5;
  localparam int SETUP_NS    = 10;   // address stable before the chip select falls
  localparam int STROBE_NS   = 50;   // chip select low time of one access
  localparam int HOLD_NS     = 10;   // address and data held after the strobe
  localparam int HSB_PULL_NS = 100;  // how long the host pulls store_busy_n low
  localparam int NV_GUARD_NS = 100;  // time given to the device to assert busy

  // a least time rounds up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SETUP_CYC    = ns_to_cyc(SETUP_NS);
  localparam int STROBE_CYC   = ns_to_cyc(STROBE_NS);
  localparam int HOLD_CYC     = ns_to_cyc(HOLD_NS);
  localparam int HSB_PULL_CYC = ns_to_cyc(HSB_PULL_NS);
  localparam int NV_GUARD_CYC = ns_to_cyc(NV_GUARD_NS);
  localparam int CNT_W        = 16;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_UBE_BIT = 4;
  localparam int CMD_LBE_BIT = 5;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_NV_BUSY = 2;
  localparam int STAT_WPEND   = 3;

  // ----------------------------------------------------------------
  // device pins and the software mode sequence
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 19;
  localparam int DATA_W  = 16;
  localparam int SEQ_LEN = 6;
  localparam logic [15:0] SEQ_A0        = 16'h4e38;
  localparam logic [15:0] SEQ_A1        = 16'hb1c7;
  localparam logic [15:0] SEQ_A2        = 16'h83e0;
  localparam logic [15:0] SEQ_A3        = 16'h7c1f;
  localparam logic [15:0] SEQ_A4        = 16'h703f;
  localparam logic [15:0] SEQ_STORE     = 16'h8fc0;
  localparam logic [15:0] SEQ_RECALL    = 16'h4c63;
  localparam logic [15:0] SEQ_AS_DISABLE = 16'h8b45;
  localparam logic [15:0] SEQ_AS_ENABLE = 16'h4b46;

  typedef enum logic [2:0] {
    OP_NONE, OP_READ, OP_WRITE, OP_SW_STORE, OP_SW_RECALL, OP_AS_DISABLE, OP_AS_ENABLE, OP_HW_STORE
  } nvs_op_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic              ube_n;
    logic              lbe_n;
  } nvs_pins_t;

  localparam nvs_pins_t PINS_IDLE = '{addr: '0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, ube_n: 1'b1, lbe_n: 1'b1};

  typedef struct packed {
    logic              valid;
    nvs_op_t           op;
    logic              ube;
    logic              lbe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nvs_cmd_t;

  typedef struct packed {
    logic              busy;
    logic              done;
    logic              nv_busy;
    logic              wpend;
    logic [DATA_W-1:0] rdata;
  } nvs_stat_t;

  function automatic logic is_seq(input nvs_op_t op);
    return (op == OP_SW_STORE) || (op == OP_SW_RECALL) || (op == OP_AS_DISABLE) || (op == OP_AS_ENABLE);
  endfunction

  // address of one step of a software sequence; the sixth step selects the action
  function automatic logic [15:0] seq_addr(input nvs_op_t op, input logic [2:0] step);
    case (step)
      3'd0:    return SEQ_A0;
      3'd1:    return SEQ_A1;
      3'd2:    return SEQ_A2;
      3'd3:    return SEQ_A3;
      3'd4:    return SEQ_A4;
      default: begin
        case (op)
          OP_SW_STORE:   return SEQ_STORE;
          OP_SW_RECALL:  return SEQ_RECALL;
          OP_AS_DISABLE: return SEQ_AS_DISABLE;
          default:       return SEQ_AS_ENABLE;
        endcase
      end
    endcase
  endfunction

endpackage

// [hw/nvs_ahb_regs.sv]
// nvs_ahb_regs: ahb-lite slave holding the controller's command and status registers.
// assumes a single master, word transfers only; zero wait states, always okay.
`timescale 1ns/1ps
module nvs_ahb_regs
  import nvs_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // controller side
  output nvs_cmd_t         o_cmd,
  input  wire nvs_stat_t   i_stat
);

  logic       wr_ph, rd_ph, done;
  logic [7:0] ph_addr;
  nvs_cmd_t   cmd;
  logic       next_wr_ph, next_rd_ph, next_done;
  logic [7:0] next_ph_addr;
  nvs_cmd_t   next_cmd;
  logic       take;

  // ----------------------------------------------------------------
  // address phase capture and register writes
  // ----------------------------------------------------------------
  always_comb begin
    // only word accesses are expected; hsize is not checked
    take         = i_hsel && i_htrans[1] && i_hready;
    next_wr_ph   = take && i_hwrite;
    next_rd_ph   = take && !i_hwrite;
    next_ph_addr = take ? i_haddr[7:0] : ph_addr;
    next_cmd     = cmd;
    next_cmd.valid = 1'b0;
    next_done    = done;
    if (wr_ph) begin
      case (ph_addr)
        REG_CMD: begin
          next_cmd.op    = nvs_op_t'(i_hwdata[CMD_OP_LSB +: 3]);
          next_cmd.ube   = i_hwdata[CMD_UBE_BIT];
          next_cmd.lbe   = i_hwdata[CMD_LBE_BIT];
          next_cmd.valid = 1'b1;
        end
        REG_ADDR:   next_cmd.addr  = i_hwdata[ADDR_W-1:0];
        REG_WDATA:  next_cmd.wdata = i_hwdata[DATA_W-1:0];
        REG_STATUS: if (i_hwdata[STAT_DONE]) next_done = 1'b0;
        default:    next_done = done;
      endcase
    end
    // a completion in the clearing cycle is kept
    if (i_stat.done) next_done = 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_ph   <= 1'b0;
      rd_ph   <= 1'b0;
      ph_addr <= 8'h00;
      done    <= 1'b0;
      cmd     <= '0;
    end else begin
      wr_ph   <= next_wr_ph;
      rd_ph   <= next_rd_ph;
      ph_addr <= next_ph_addr;
      done    <= next_done;
      cmd     <= next_cmd;
    end
  end

  // ----------------------------------------------------------------
  // read mux of flops and the store_busy_n pin; unmapped offsets read zero
  // ----------------------------------------------------------------
  always_comb begin
    o_hrdata = 32'h0000_0000;
    if (rd_ph) begin
      case (ph_addr)
        REG_CMD:    o_hrdata = {26'h0, cmd.lbe, cmd.ube, 1'b0, cmd.op};
        REG_ADDR:   o_hrdata = {13'h0, cmd.addr};
        REG_WDATA:  o_hrdata = {16'h0, cmd.wdata};
        REG_RDATA:  o_hrdata = {16'h0, i_stat.rdata};
        REG_STATUS: o_hrdata = {28'h0, i_stat.wpend, i_stat.nv_busy, done, i_stat.busy};
        default:    o_hrdata = 32'h0000_0000;
      endcase
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_cmd       = cmd;

endmodule // nvs_ahb_regs

// [hw/nvs_host_ctrl.sv]
// nvs_host_ctrl: host side controller that drives an nvsram through its sram pins and store_busy_n.
// assumes pin inputs synchronous to i_clk and one word-wide ahb-lite master for its registers.
`timescale 1ns/1ps
module nvs_host_ctrl
  import nvs_pkg::*;
#(
  parameter int P_SETUP_CYC    = SETUP_CYC,
  parameter int P_STROBE_CYC   = STROBE_CYC,
  parameter int P_HOLD_CYC     = HOLD_CYC,
  parameter int P_HSB_PULL_CYC = HSB_PULL_CYC,
  parameter int P_NV_GUARD_CYC = NV_GUARD_CYC
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  // ahb-lite slave
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  output logic [31:0]            o_hrdata,
  // nvsram pins
  output logic [ADDR_W-1:0]      o_addr,
  output logic                   o_ce_n,
  output logic                   o_we_n,
  output logic                   o_oe_n,
  output logic                   o_upper_byte_enable_n,
  output logic                   o_lower_byte_enable_n,
  input  wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0]      o_dq,
  output logic                   o_dq_oe,
  // store_busy_n, open drain
  input  wire logic              i_store_busy_n,
  output logic                   o_store_busy_n,
  output logic                   o_store_busy_n_oe
);

  typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_HSB_PULL, ST_NV_WAIT} nvs_state_t;

  nvs_cmd_t          cmd;
  nvs_stat_t         stat;
  nvs_state_t        state, next_state;
  nvs_op_t           op, next_op;
  nvs_pins_t         pins, next_pins;
  logic [2:0]        step, next_step;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic [DATA_W-1:0] dq_out, next_dq_out, rdata, next_rdata;
  logic              dq_oe, next_dq_oe, sb_pull, next_sb_pull;
  logic              done, next_done, wpend, next_wpend;

  nvs_ahb_regs u_regs (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hsize     (i_hsize),
    .i_hwdata    (i_hwdata),
    .i_hready    (i_hready),
    .o_hreadyout (o_hreadyout),
    .o_hresp     (o_hresp),
    .o_hrdata    (o_hrdata),
    .o_cmd       (cmd),
    .i_stat      (stat)
  );

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state   = state;
    next_op      = op;
    next_pins    = pins;
    next_step    = step;
    next_cnt     = (cnt != '0) ? cnt - 1'b1 : cnt;
    next_dq_out  = dq_out;
    next_dq_oe   = dq_oe;
    next_rdata   = rdata;
    next_sb_pull = sb_pull;
    next_done    = 1'b0;
    next_wpend   = wpend;
    case (state)
      ST_IDLE: begin
        // commands while the device is busy are dropped: it stays deselected until the pin rises
        if (cmd.valid && cmd.op != OP_NONE && i_store_busy_n) begin
          next_op = cmd.op;
          if (cmd.op == OP_HW_STORE) begin
            next_sb_pull = 1'b1;
            next_cnt     = CNT_W'(P_HSB_PULL_CYC - 1);
            next_state   = ST_HSB_PULL;
          end else begin
            next_state = ST_SETUP;
            next_cnt   = CNT_W'(P_SETUP_CYC - 1);
            if (is_seq(cmd.op)) begin
              next_step       = 3'd0;
              next_pins.addr  = ADDR_W'(seq_addr(cmd.op, 3'd0));
              next_pins.ube_n = 1'b0;
              next_pins.lbe_n = 1'b0;
            end else begin
              next_step       = 3'(SEQ_LEN - 1);
              next_pins.addr  = cmd.addr;
              next_pins.ube_n = !cmd.ube;
              next_pins.lbe_n = !cmd.lbe;
              next_dq_out     = cmd.wdata;
              next_dq_oe      = (cmd.op == OP_WRITE);
            end
          end
        end
      end
      ST_SETUP: begin
        if (cnt == '0) begin
          next_pins.ce_n = 1'b0;
          // sequence steps are plain reads, the write strobe never falls
          next_pins.we_n = (op != OP_WRITE);
          next_pins.oe_n = (op == OP_WRITE);
          next_cnt       = CNT_W'(P_STROBE_CYC - 1);
          next_state     = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (cnt == '0) begin
          if (op != OP_WRITE) next_rdata = i_dq;
          next_pins.ce_n = 1'b1;
          next_pins.we_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_cnt       = CNT_W'(P_HOLD_CYC - 1);
          next_state     = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cnt == '0) begin
          next_dq_oe = 1'b0;
          if (step != 3'(SEQ_LEN - 1)) begin
            // next step follows at once; nothing else is let in between
            next_step      = step + 3'd1;
            next_pins.addr = ADDR_W'(seq_addr(op, step + 3'd1));
            next_cnt       = CNT_W'(P_SETUP_CYC - 1);
            next_state     = ST_SETUP;
          end else if (is_seq(op)) begin
            next_cnt   = CNT_W'(P_NV_GUARD_CYC - 1);
            next_state = ST_NV_WAIT;
          end else begin
            if (op == OP_WRITE) next_wpend = 1'b1;
            next_pins  = PINS_IDLE;
            next_done  = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_HSB_PULL: begin
        if (cnt == '0) begin
          next_sb_pull = 1'b0;
          next_cnt     = CNT_W'(P_NV_GUARD_CYC - 1);
          next_state   = ST_NV_WAIT;
        end
      end
      ST_NV_WAIT: begin
        // the guard lets the device take the pin low before the host trusts a high level
        if (cnt == '0 && i_store_busy_n) begin
          if (op == OP_SW_STORE || op == OP_SW_RECALL || op == OP_HW_STORE) next_wpend = 1'b0;
          next_pins  = PINS_IDLE;
          next_done  = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_pins  = PINS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state   <= ST_IDLE;
      op      <= OP_NONE;
      pins    <= PINS_IDLE;
      step    <= 3'd0;
      cnt     <= '0;
      dq_out  <= '0;
      dq_oe   <= 1'b0;
      rdata   <= '0;
      sb_pull <= 1'b0;
      done    <= 1'b0;
      wpend   <= 1'b0;
    end else begin
      state   <= next_state;
      op      <= next_op;
      pins    <= next_pins;
      step    <= next_step;
      cnt     <= next_cnt;
      dq_out  <= next_dq_out;
      dq_oe   <= next_dq_oe;
      rdata   <= next_rdata;
      sb_pull <= next_sb_pull;
      done    <= next_done;
      wpend   <= next_wpend;
    end
  end

  assign stat = '{busy: (state != ST_IDLE), done: done, nv_busy: !i_store_busy_n, wpend: wpend, rdata: rdata};

  assign o_addr                = pins.addr;
  assign o_ce_n                = pins.ce_n;
  assign o_we_n                = pins.we_n;
  assign o_oe_n                = pins.oe_n;
  assign o_upper_byte_enable_n = pins.ube_n;
  assign o_lower_byte_enable_n = pins.lbe_n;
  assign o_dq                  = dq_out;
  assign o_dq_oe               = dq_oe;
  assign o_store_busy_n        = 1'b0;
  assign o_store_busy_n_oe     = sb_pull;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  seq_we_high_a: assert property (is_seq(op) && state != ST_IDLE |-> pins.we_n && !dq_oe)
    else $error("write strobe low inside a software sequence");
  seq_prefix_a: assert property ($fell(pins.ce_n) && is_seq(op) && step < 3'd5
                                 |-> pins.addr[15:0] == seq_addr(op, step))
    else $error("sequence prefix address wrong");
  seq_store_a: assert property ($fell(pins.ce_n) && op == OP_SW_STORE && step == 3'd5
                                |-> pins.addr[15:0] == 16'h8fc0)
    else $error("store sequence sixth address wrong");
  seq_recall_a: assert property ($fell(pins.ce_n) && op == OP_SW_RECALL && step == 3'd5
                                 |-> pins.addr[15:0] == 16'h4c63)
    else $error("recall sequence sixth address wrong");
  seq_disable_a: assert property ($fell(pins.ce_n) && op == OP_AS_DISABLE && step == 3'd5
                                  |-> pins.addr[15:0] == 16'h8b45)
    else $error("autostore disable sixth address wrong");
  seq_enable_a: assert property ($fell(pins.ce_n) && op == OP_AS_ENABLE && step == 3'd5
                                 |-> pins.addr[15:0] == 16'h4b46)
    else $error("autostore enable sixth address wrong");
  seq_step_inc_a: assert property (state != ST_IDLE && $past(state) != ST_IDLE && step != $past(step)
                                   |-> step == $past(step) + 3'd1)
    else $error("sequence step skipped or repeated");
  seq_read_oe_a: assert property (is_seq(op) && $fell(pins.ce_n) |-> !pins.oe_n ##1 !pins.ce_n && pins.we_n)
    else $error("sequence step is not a read");

endmodule // nvs_host_ctrl

// [tb/nvs_dev_model.sv]
// nvs_dev_model: behavioural nvsram at its pins, facing the host controller.
// assumes pins change just after i_clk edges; supply loss arrives as a level on i_pwr_low.
`timescale 1ns/1ps
module nvs_dev_model
  import nvs_pkg::*;
#(
  parameter int P_ST  = 40,
  parameter int P_DLY = 4,
  parameter int P_PU  = 30
) (
  // clock
  input  wire logic              i_clk,
  // sram pins
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_ce_n,
  input  wire logic              i_we_n,
  input  wire logic              i_oe_n,
  input  wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0]      o_dq,
  // store_busy_n wire
  input  wire logic              i_store_busy_n,
  output logic                   o_pull,
  // supply sense, high while supply is below the switch level
  input  wire logic              i_pwr_low,
  // observation
  output int                     o_n_store,
  output int                     o_n_recall,
  output logic                   o_as_en
);
  // ----------------------------------------------------------------
  // array, sequence detector, busy timer
  // ----------------------------------------------------------------
  localparam logic [15:0] PRE [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] nv [256];
  logic [DATA_W-1:0] last = '0;
  logic [12:0]       a;
  logic              ce_q = 1'b1;
  logic              wpend = 1'b0;
  logic              pf_q = 1'b0;
  int                step = 0;
  int                bcnt = P_PU;
  int                hcnt = 0;

  initial begin
    o_n_store = 0;
    o_n_recall = 0;
    o_as_en = 1'b1;
  end

  assign a = i_addr[14:2];
  assign o_pull = bcnt > 0;
  // a released bus toggles, so stale data never passes for a read
  assign o_dq = (!i_ce_n && !i_oe_n && i_we_n && bcnt == 0) ? mem[i_addr[7:0]] : ~last;

  task store;
    foreach (nv[i]) nv[i] = mem[i];
    bcnt <= P_ST;
    wpend <= 1'b0;
    o_n_store <= o_n_store + 1;
  endtask

  always @(posedge i_clk) begin
    last <= o_dq;
    ce_q <= i_ce_n;
    pf_q <= i_pwr_low;
    if (i_pwr_low) begin
      // the capacitor carries one store at the drop; the recall waits for supply
      if (!pf_q && o_as_en && wpend) begin
        foreach (nv[i]) nv[i] = mem[i];
        o_n_store <= o_n_store + 1;
      end
      bcnt <= P_PU;
      step <= 0;
    end else if (pf_q) begin
      foreach (mem[i]) mem[i] <= nv[i];
      wpend <= 1'b0;
      o_n_recall <= o_n_recall + 1;
    end else if (bcnt > 0) begin
      bcnt <= bcnt - 1;
      hcnt <= 0;
    end else if (!i_store_busy_n) begin
      hcnt <= hcnt + 1;
      if (hcnt == P_DLY && wpend) begin
        store();
      end
    end else begin
      hcnt <= 0;
      if (ce_q && !i_ce_n && !i_we_n) begin
        mem[i_addr[7:0]] <= i_dq;
        wpend <= 1'b1;
        step <= 0;
      end else if (ce_q && !i_ce_n) begin
        step <= (a == SEQ_A0[14:2]) ? 1 : 0;
        if (step < 5 && a == PRE[step][14:2]) begin
          step <= step + 1;
        end else if (step == 5 && a == SEQ_STORE[14:2]) begin
          store();
        end else if (step == 5 && a == SEQ_RECALL[14:2]) begin
          foreach (mem[i]) mem[i] <= nv[i];
          bcnt <= P_ST;
          wpend <= 1'b0;
          o_n_recall <= o_n_recall + 1;
        end else if (step == 5 && a == SEQ_AS_DISABLE[14:2]) begin
          o_as_en <= 1'b0;
        end else if (step == 5 && a == SEQ_AS_ENABLE[14:2]) begin
          o_as_en <= 1'b1;
        end
      end
    end
  end
endmodule  // nvs_dev_model

// [tb/nvs_host_ctrl_tb_top.sv]
// nvs_host_ctrl_tb_top: self-checking bench for the nvsram host controller.
// assumes the device model on the far side and one ahb-lite master here.
`timescale 1ns/1ps
module nvs_host_ctrl_tb_top
  import nvs_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_hsel = 1'b0;
  logic i_hwrite = 1'b0;
  logic [1:0] i_htrans = '0;
  logic [31:0] i_haddr = '0;
  logic [31:0] i_hwdata = '0;
  logic [31:0] o_hrdata, rd;
  logic [ADDR_W-1:0] o_addr;
  logic [DATA_W-1:0] o_dq, dev_dq;
  logic [DATA_W-1:0] exp_d [4];
  logic [7:0] adr [4];
  logic o_hreadyout, o_ce_n, o_we_n, o_oe_n, o_dq_oe, sb_oe, pull, sb_n, as_en, wp;
  logic pwr_low = 1'b0, o_sb, hresp, ube_n, lbe_n;
  logic [1:0] be_seen = 2'b00;
  int err_count = 0, cmp_count = 0, cyc = 0, seed = 77, st_cnt, rc_cnt, est = 0, erc = 0;

  always #2.5 i_clk = ~i_clk;
  // open-drain wire with pull-up
  assign sb_n = !((sb_oe && !o_sb) || pull);

  nvs_host_ctrl dut_u (
    .i_clk(i_clk), .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hreadyout(o_hreadyout), .o_hresp(hresp), .o_hrdata(o_hrdata), .o_addr(o_addr), .o_ce_n(o_ce_n),
    .o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_upper_byte_enable_n(ube_n), .o_lower_byte_enable_n(lbe_n),
    .i_dq(dev_dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_store_busy_n(sb_n), .o_store_busy_n(o_sb),
    .o_store_busy_n_oe(sb_oe));

  nvs_dev_model dev_u (
    .i_clk(i_clk), .i_addr(o_addr), .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
    .i_dq(o_dq_oe ? o_dq : ~dev_dq), .o_dq(dev_dq), .i_store_busy_n(sb_n), .o_pull(pull),
    .i_pwr_low(pwr_low), .o_n_store(st_cnt), .o_n_recall(rc_cnt), .o_as_en(as_en));

  // ----------------------------------------------------------------
  // tasks and expectation functions
  // ----------------------------------------------------------------
  function automatic int exp_store(input nvs_op_t op, input logic w);
    return (op == OP_SW_STORE || (op == OP_HW_STORE && w)) ? 1 : 0;
  endfunction

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    i_hsel <= 1'b1;
    i_haddr <= {24'h0, a};
    i_hwrite <= w;
    i_htrans <= 2'h2;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    r = o_hrdata;
  endtask

  task automatic cmd(input nvs_op_t op);
    logic [31:0] s;
    ahb(1'b1, REG_CMD, 32'h30 | {29'h0, op}, s);
    do ahb(1'b0, REG_STATUS, '0, s); while (s[STAT_DONE] !== 1'b1);
    chk("busy and wire", 32'h0, {29'h0, s[STAT_NV_BUSY], 1'b0, s[STAT_BUSY]});
    chk("resp and byte enables", 32'h0, {29'h0, hresp, be_seen});
    ahb(1'b1, REG_STATUS, 32'h2, s);
  endtask

  task automatic dev_acc(input nvs_op_t op, input logic [7:0] a, input logic [15:0] d);
    ahb(1'b1, REG_ADDR, {24'h0, a}, rd);
    ahb(1'b0, REG_ADDR, '0, rd);
    chk("addr reg", {24'h0, a}, rd);
    ahb(1'b1, REG_WDATA, {16'h0, d}, rd);
    cmd(op);
    if (op == OP_WRITE) wp = 1'b1;
    ahb(1'b0, REG_RDATA, '0, rd);
  endtask

  task automatic nv_op(input nvs_op_t op);
    est = est + exp_store(op, wp);
    if (op == OP_SW_RECALL) erc++;
    if (exp_store(op, wp) == 1 || op == OP_SW_RECALL) wp = 1'b0;
    cmd(op);
    chk("stores", 32'(est), 32'(st_cnt));
    chk("recalls", 32'(erc), 32'(rc_cnt));
    $display("test op %0d done", op);
  endtask

  // supply dip while idle: autostore only when enabled, recall always
  task automatic pwr_dip(input logic on, input logic [15:0] e);
    dev_acc(OP_WRITE, adr[1], ~exp_d[1]);
    est = est + (on ? 1 : 0);
    erc++;
    wp = 1'b0;
    pwr_low <= 1'b1;
    repeat (3) @(posedge i_clk);
    pwr_low <= 1'b0;
    repeat (2) @(posedge i_clk);
    while (sb_n !== 1'b1) @(posedge i_clk);
    chk("stores", 32'(est), 32'(st_cnt));
    chk("recalls", 32'(erc), 32'(rc_cnt));
    dev_acc(OP_READ, adr[1], 16'h0);
    chk("power cycle", {16'h0, e}, rd);
    $display("test power dip done");
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (!o_ce_n) be_seen <= be_seen | {ube_n, lbe_n};
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    wp = 1'b0;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    chk("powerup wire", 32'h0, {31'h0, sb_n});
    while (sb_n !== 1'b1) @(posedge i_clk);
    ahb(1'b0, REG_STATUS, '0, rd);
    chk("status", 32'h0, rd);
    ahb(1'b1, 8'h20, 32'hffff, rd);
    ahb(1'b0, 8'h20, '0, rd);
    chk("unmapped", 32'h0, rd);
    chk("autostore", 32'h1, {31'h0, as_en});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      adr[i] = {6'($random(seed)), 2'(i)};
      exp_d[i] = (i == 0) ? 16'hffff : 16'($random(seed));
      dev_acc(OP_WRITE, adr[i], exp_d[i]);
    end
    for (int i = 0; i < 4; i++) begin
      dev_acc(OP_READ, adr[i], 16'h0);
      chk("rdata", {16'h0, exp_d[i]}, rd);
    end
    ahb(1'b0, REG_STATUS, '0, rd);
    chk("pending", 32'h8, rd);
    $display("test sram done");
    nv_op(OP_HW_STORE);
    nv_op(OP_HW_STORE);
    nv_op(OP_SW_STORE);
    dev_acc(OP_WRITE, adr[0], ~exp_d[0]);
    nv_op(OP_SW_RECALL);
    dev_acc(OP_READ, adr[0], 16'h0);
    chk("recalled", {16'h0, exp_d[0]}, rd);
    nv_op(OP_AS_DISABLE);
    chk("autostore", 32'h0, {31'h0, as_en});
    pwr_dip(1'b0, exp_d[1]);
    nv_op(OP_AS_ENABLE);
    chk("autostore", 32'h1, {31'h0, as_en});
    pwr_dip(1'b1, ~exp_d[1]);
    final_report();
  end
endmodule  // nvs_host_ctrl_tb_top
